// ==== core/fsw_cfg.svh ====
// Constants for the status-word flag logic: widths, bit positions, reset values
`ifndef FSW_CFG_SVH
`define FSW_CFG_SVH

`define FSW_WIDTH        16
`define FSW_NUM_EXC      6
`define FSW_BIT_IE       0
`define FSW_BIT_DE       1
`define FSW_BIT_ZE       2
`define FSW_BIT_OE       3
`define FSW_BIT_UE       4
`define FSW_BIT_PE       5
`define FSW_BIT_SF       6
`define FSW_BIT_ES       7
`define FSW_BIT_C0       8
`define FSW_BIT_C1       9
`define FSW_BIT_C2       10
`define FSW_TOP_LO       11
`define FSW_TOP_HI       13
`define FSW_BIT_C3       14
`define FSW_BIT_BUSY     15
`define FSW_RESET_EXC    6'h00
`define FSW_RESET_COND   4'h0
`define FSW_RESET_TOP    3'h0

`endif

// ==== core/fsw_pkg.sv ====
// Types shared by the status-word flag logic
package fsw_pkg;

  // Instruction classes, as they affect the condition flags
  typedef enum logic [3:0] {
    FSW_OP_NONE      = 4'h0,  // Flags untouched
    FSW_OP_COMPARE   = 4'h1,  // Ordinary / unordered / integer compare and test
    FSW_OP_COMPARE_I = 4'h2,  // Compare that writes the integer flags register
    FSW_OP_EXAMINE   = 4'h3,
    FSW_OP_PREM      = 4'h4,  // Both partial remainder forms
    FSW_OP_ARITH     = 4'h5,
    FSW_OP_TRIG      = 4'h6,
    FSW_OP_LOAD      = 4'h7,  // Load, abs, chs, stack step, exchange, extract
    FSW_OP_MISC      = 4'h8,  // Free, cw load, no-op, cw/env/status store
    FSW_OP_CLEX      = 4'h9,
    FSW_OP_INIT      = 4'hA,  // Reinitialise and state save
    FSW_OP_RESTORE   = 4'hB   // Environment load and state restore
  } fsw_op_t;

  // Sticky exception flags, bit 5 first (invalid operation ends up in bit 0)
  typedef struct packed {
    logic inexact_result_flag;
    logic underflow_flag;
    logic overflow_flag;
    logic divide_by_zero_flag;
    logic denormal_operand_flag;
    logic invalid_op_flag;
  } fsw_exc_t;

  // Condition flags in a compact order
  typedef struct packed {
    logic cond_flag_three;
    logic cond_flag_two;
    logic cond_flag_one;
    logic cond_flag_zero;
  } fsw_cond_t;

  // One completing instruction, reported by the execution pipeline
  typedef struct packed {
    logic      valid;
    fsw_op_t   op;
    fsw_exc_t  exc;          // Exceptions detected by this instruction
    logic      stack_fault;  // Stack overflow or underflow detected
    logic      stack_over;   // 1 overflow, 0 underflow
    fsw_cond_t result;       // Compare outcome, class/sign, quotient bits
    logic      round_up;
    logic      incomplete;   // Remainder reduction not finished / trig out of range
    logic [2:0] new_top;
    logic      top_we;
    logic [15:0] image;      // Status word from memory for restore
  } fsw_req_t;

  // Whole state of the flag logic
  typedef struct packed {
    fsw_exc_t   exc;
    logic       sf;
    fsw_cond_t  cond;
    logic [2:0] top;
  } fsw_state_t;

endpackage : fsw_pkg

// ==== core/fsw_summary.sv ====
// Exception summary and handler request from flags and masks
`timescale 1ns/1ps
`default_nettype none
`include "fsw_cfg.svh"

module fsw_summary
  import fsw_pkg::*;
(
  input  wire logic     mclk,
  input  wire logic     resetn,
  input  wire fsw_exc_t flags,
  input  wire fsw_exc_t mask,
  output logic          summary,
  output logic          handler_req
);

  typedef struct packed {
    logic prev;
  } fsw_sum_state_t;

  fsw_sum_state_t st_q;
  fsw_sum_state_t st_d;

  // Masked flags still stand, they just cannot raise the summary
  assign summary     = |(flags & ~mask);
  // Pulse on the rising edge of the summary
  assign handler_req = summary & ~st_q.prev;

  always_comb begin
    st_d      = st_q;
    st_d.prev = summary;
  end

  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule : fsw_summary

`default_nettype wire

// ==== core/fsw_flags.sv ====
// Floating-point status word flag logic
`timescale 1ns/1ps
`default_nettype none
`include "fsw_cfg.svh"

// Notes on behaviour
// - Six exception flags in low bits
// - Summary bit 7 from unmasked set flags
// - Masked exception sets flag, not summary
// - Summary rising raises handler request
// - Exception flags sticky until explicit clear
// - Clear-exceptions clears all exception flags
// - Init and save clear flags and conditions
// - Restore and env load overwrite from image
// - Bit 15 mirrors the summary flag
// - Compares write C0 C3 C2; C1 zero/fault
// - Integer-flag compares: C1 fault only
// - Arithmetic: C1 shows round-up or fault
// - Trig: C2 out-of-range, C1 round-up
// - Loads: C1 zero or fault
// - Misc ops may leave conditions unchanged
// - Stack fault bit 6 on overflow/underflow
// - Invalid operand alone keeps stack fault
// - With fault, C1 is overflow direction, except examine and incomplete trig
// - Stack fault cleared only by init/clex/save or restore from image
// - Stack fault also sets invalid flag
// - Examine: C1 sign, others class
// - Remainder: C2 incomplete, quotient bits
// - Top pointer in bits 11 to 13
module fsw_flags
  import fsw_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire fsw_req_t    req,
  input  wire fsw_exc_t    exc_mask,
  output logic [15:0]      fp_status_word,
  output logic             exception_summary_flag,
  output logic             handler_req
);

  fsw_state_t st_q;
  fsw_state_t st_d;
  logic       summary;

  // ****************************************************************
  // Summary and handler request
  // ****************************************************************
  fsw_summary u_summary (
    .mclk        (mclk),
    .resetn      (resetn),
    .flags       (st_q.exc),
    .mask        (exc_mask),
    .summary     (summary),
    .handler_req (handler_req)
  );

  assign exception_summary_flag = summary;

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // C1 value shared by several classes: fault direction wins over the
  // class's own meaning, since a faulting instruction produced no result
  function automatic logic c1_sel(input logic fault, input logic over, input logic other);
    c1_sel = fault ? over : other;
  endfunction : c1_sel

  always_comb begin
    fsw_exc_t new_exc;
    new_exc = req.exc;
    st_d    = st_q;
    if (req.valid) begin
      if (req.stack_fault) begin
        new_exc.invalid_op_flag = 1'b1;
      end
      // Sticky accumulate; only the explicit ops below clear
      st_d.exc = st_q.exc | new_exc;
      st_d.sf  = st_q.sf | req.stack_fault;
      if (req.top_we) begin
        st_d.top = req.new_top;
      end
      unique case (req.op)
        FSW_OP_COMPARE: begin
          st_d.cond.cond_flag_zero  = req.result.cond_flag_zero;
          st_d.cond.cond_flag_two   = req.result.cond_flag_two;
          st_d.cond.cond_flag_three = req.result.cond_flag_three;
          st_d.cond.cond_flag_one   = c1_sel(req.stack_fault, req.stack_over, 1'b0);
        end
        FSW_OP_COMPARE_I: begin
          // Other flags left as they were, which is one legal undefined
          st_d.cond.cond_flag_one = c1_sel(req.stack_fault, req.stack_over,
                                           st_q.cond.cond_flag_one);
        end
        FSW_OP_EXAMINE: begin
          st_d.cond.cond_flag_zero  = req.result.cond_flag_zero;
          st_d.cond.cond_flag_two   = req.result.cond_flag_two;
          st_d.cond.cond_flag_three = req.result.cond_flag_three;
          st_d.cond.cond_flag_one   = req.result.cond_flag_one;
        end
        FSW_OP_PREM: begin
          st_d.cond.cond_flag_two = req.incomplete;
          if (!req.incomplete) begin
            st_d.cond.cond_flag_zero  = req.result.cond_flag_zero;
            st_d.cond.cond_flag_three = req.result.cond_flag_three;
          end
          st_d.cond.cond_flag_one = c1_sel(req.stack_fault, req.stack_over,
                                           req.incomplete ? st_q.cond.cond_flag_one
                                                          : req.result.cond_flag_one);
        end
        FSW_OP_ARITH: begin
          st_d.cond.cond_flag_one = c1_sel(req.stack_fault, req.stack_over,
                                           req.round_up);
        end
        FSW_OP_TRIG: begin
          st_d.cond.cond_flag_two = req.incomplete;
          if (!req.incomplete) begin
            st_d.cond.cond_flag_one = c1_sel(req.stack_fault, req.stack_over,
                                             req.round_up);
          end
        end
        FSW_OP_LOAD: begin
          st_d.cond.cond_flag_one = c1_sel(req.stack_fault, req.stack_over, 1'b0);
        end
        FSW_OP_MISC: begin
          st_d.cond = st_q.cond;
        end
        FSW_OP_CLEX: begin
          st_d.exc = `FSW_RESET_EXC;
          st_d.sf  = 1'b0;
        end
        FSW_OP_INIT: begin
          st_d.exc  = `FSW_RESET_EXC;
          st_d.sf   = 1'b0;
          st_d.cond = `FSW_RESET_COND;
          st_d.top  = `FSW_RESET_TOP;
        end
        FSW_OP_RESTORE: begin
          st_d.exc  = req.image[`FSW_NUM_EXC-1:0];
          st_d.sf   = req.image[`FSW_BIT_SF];
          st_d.cond = {req.image[`FSW_BIT_C3], req.image[`FSW_BIT_C2],
                       req.image[`FSW_BIT_C1], req.image[`FSW_BIT_C0]};
          st_d.top  = req.image[`FSW_TOP_HI:`FSW_TOP_LO];
        end
        default: begin
          st_d.cond = st_q.cond;
        end
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  // One register for everything so a store sees a whole instruction
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ****************************************************************
  // Status word assembly
  // ****************************************************************
  always_comb begin
    fp_status_word                               = '0;
    fp_status_word[`FSW_NUM_EXC-1:0]             = st_q.exc;
    fp_status_word[`FSW_BIT_SF]                  = st_q.sf;
    fp_status_word[`FSW_BIT_ES]                  = summary;
    fp_status_word[`FSW_BIT_C0]                  = st_q.cond.cond_flag_zero;
    fp_status_word[`FSW_BIT_C1]                  = st_q.cond.cond_flag_one;
    fp_status_word[`FSW_BIT_C2]                  = st_q.cond.cond_flag_two;
    fp_status_word[`FSW_TOP_HI:`FSW_TOP_LO]      = st_q.top;
    fp_status_word[`FSW_BIT_C3]                  = st_q.cond.cond_flag_three;
    fp_status_word[`FSW_BIT_BUSY]                = summary;
  end

endmodule : fsw_flags

`default_nettype wire

// ==== testbench/fsw_pipe_model.sv ====
// Execution pipeline model that reports completing instructions
`timescale 1ns/1ps
`default_nettype none
module fsw_pipe_model
  import fsw_pkg::*;
(
  input  wire logic   mclk,
  output var fsw_req_t req
);
  // ****************************************
  // Instruction reporting
  // ****************************************
  initial req = '0;
  // One valid cycle per instruction, launched just after an edge
  task automatic issue(input fsw_op_t op, input logic [5:0] exc, input logic [3:0] res,
                       input logic [3:0] misc, input logic [15:0] img);
    fsw_req_t idle;
    @(posedge mclk);
    #1;
    req = {1'b1, op, exc, misc[3], misc[2], res, misc[1], misc[0], 3'h0, 1'b0, img};
    @(posedge mclk);
    #1;
    // Idle fields flip so nothing can lean on stale request data
    idle       = ~req;
    idle.valid = 1'b0;
    req        = idle;
  endtask : issue
endmodule : fsw_pipe_model
`default_nettype wire

// ==== testbench/fsw_flags_chk.sv ====
// Port checker for the status-word flag logic
`timescale 1ns/1ps
`default_nettype none
module fsw_flags_chk
  import fsw_pkg::*;
(
  input wire logic        mclk,
  input wire logic        resetn,
  input wire fsw_req_t    req,
  input wire fsw_exc_t    exc_mask,
  input wire logic [15:0] fp_status_word,
  input wire logic        exception_summary_flag,
  input wire logic        handler_req
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  logic [15:0] w;
  logic        ovr;
  assign w   = fp_status_word;
  // Only these ops may drop sticky flags
  assign ovr = req.valid && (req.op inside {FSW_OP_CLEX, FSW_OP_INIT, FSW_OP_RESTORE});
  sequence s_rise; !exception_summary_flag ##1 exception_summary_flag; endsequence
  property p_sum;
    (exception_summary_flag == |(w[5:0] & ~exc_mask)) && (w[7] == w[15])
      && (w[7] == exception_summary_flag);
  endproperty
  property p_hreq; s_rise |-> handler_req ##1 !handler_req; endproperty
  property p_sticky; !ovr |=> ((w & $past(w)) & 16'h007F) == ($past(w) & 16'h007F); endproperty
  property p_clex; req.valid && req.op == FSW_OP_CLEX |=> w[6:0] == 7'h00; endproperty
  property p_init; req.valid && req.op == FSW_OP_INIT |=> (w & 16'h7F7F) == 16'h0000; endproperty
  property p_rest;
    req.valid && req.op == FSW_OP_RESTORE |=> (w & 16'h7F7F) == ($past(req.image) & 16'h7F7F);
  endproperty
  property p_fault;
    req.valid && req.stack_fault && (req.op inside {FSW_OP_COMPARE, FSW_OP_ARITH, FSW_OP_LOAD})
      |=> w[0] && w[6] && w[9] == $past(req.stack_over);
  endproperty
  property p_cmp;
    req.valid && req.op == FSW_OP_COMPARE && !req.stack_fault
      |=> {w[14], w[10], w[9], w[8]} == ($past(req.result) & 4'hD);
  endproperty
  property p_hold;
    req.valid && (req.op inside {FSW_OP_MISC, FSW_OP_COMPARE_I}) |=> $stable({w[14], w[10], w[8]});
  endproperty
  a_sum: assert property (p_sum)
    else $error("summary flag wrong");
  a_hreq: assert property (p_hreq)
    else $error("handler request not a single pulse");
  a_sticky: assert property (p_sticky)
    else $error("sticky flag dropped");
  a_clex: assert property (p_clex)
    else $error("clear left flags set");
  a_init: assert property (p_init)
    else $error("init left state");
  a_rest: assert property (p_rest)
    else $error("restore mismatch");
  a_fault: assert property (p_fault)
    else $error("stack fault report wrong");
  a_cmp: assert property (p_cmp)
    else $error("compare flags wrong");
  a_hold: assert property (p_hold)
    else $error("condition flags moved");
endmodule : fsw_flags_chk
bind fsw_flags fsw_flags_chk u_chk (.mclk(mclk), .resetn(resetn), .req(req), .exc_mask(exc_mask),
  .fp_status_word(fp_status_word), .exception_summary_flag(exception_summary_flag),
  .handler_req(handler_req));
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Self-checking bench for the status-word flag logic
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import fsw_pkg::*;
;
  // ****************************************
  // Harness
  // ****************************************
  logic        mclk;
  logic        resetn;
  fsw_exc_t    exc_mask;
  fsw_req_t    req;
  logic [15:0] word;
  logic        summ;
  logic        hreq;
  int          num_errors = 0;
  int          tests_run = 0;
  int          cycles = 0;
  fsw_pipe_model u_pipe (.mclk(mclk), .req(req));
  fsw_flags u_dut (.mclk(mclk), .resetn(resetn), .req(req), .exc_mask(exc_mask),
    .fp_status_word(word), .exception_summary_flag(summ), .handler_req(hreq));
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic go(input fsw_op_t o, input logic [5:0] e, input logic [3:0] r, input logic [3:0] m);
    u_pipe.issue(o, e, r, m, 16'h0000);
  endtask : go
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  task automatic t_walk();
    go(FSW_OP_ARITH, 6'h01, 4'h0, 4'hC);
    check(word, 16'h82C1);
    check({15'h0000, hreq}, 16'h0001);
    @(posedge mclk);
    #1;
    check({15'h0000, hreq}, 16'h0000);
    go(FSW_OP_CLEX, 6'h00, 4'h0, 4'h0);
    check(word, 16'h0200);
    $display("test walk done");
  endtask : t_walk
  task automatic t_mask();
    exc_mask = 6'h3F;
    go(FSW_OP_ARITH, 6'h04, 4'h0, 4'h0);
    check(word, 16'h0004);
    check({15'h0000, summ}, 16'h0000);
    exc_mask = 6'h3B;
    #1;
    check(word, 16'h8084);
    check({15'h0000, summ}, 16'h0001);
    check({15'h0000, hreq}, 16'h0001);
    go(FSW_OP_LOAD, 6'h00, 4'h0, 4'h0);
    check(word, 16'h8084);
    go(FSW_OP_ARITH, 6'h00, 4'h0, 4'h8);
    check(word, 16'h80C5);
    go(FSW_OP_LOAD, 6'h01, 4'h0, 4'h0);
    check(word, 16'h80C5);
    go(FSW_OP_CLEX, 6'h00, 4'h0, 4'h0);
    check(word, 16'h0000);
    $display("test mask done");
  endtask : t_mask
  task automatic t_cond();
    exc_mask = 6'h3F;
    for (int i = 0; i < 8; i++) begin
      go(FSW_OP_COMPARE, 6'h00, {i[2], i[1], 1'b1, i[0]}, 4'h0);
      check(word, {1'b0, i[2], 3'h0, i[1], 1'b0, i[0], 8'h00});
    end
    go(FSW_OP_COMPARE_I, 6'h00, 4'h0, 4'h0);
    check(word & 16'h4500, 16'h4500);
    go(FSW_OP_TRIG, 6'h00, 4'h0, 4'h3);
    check(word & 16'h4500, 16'h4500);
    go(FSW_OP_TRIG, 6'h00, 4'h0, 4'h2);
    check(word, 16'h4300);
    go(FSW_OP_PREM, 6'h00, 4'h9, 4'h0);
    check(word, 16'h4100);
    go(FSW_OP_PREM, 6'h00, 4'h2, 4'h1);
    check(word, 16'h4500);
    go(FSW_OP_EXAMINE, 6'h00, 4'h6, 4'h0);
    check(word, 16'h0600);
    go(FSW_OP_ARITH, 6'h00, 4'h0, 4'h0);
    check(word, 16'h0400);
    $display("test cond done");
  endtask : t_cond
  task automatic t_rest();
    u_pipe.issue(FSW_OP_RESTORE, 6'h00, 4'h0, 4'h0, 16'hFFFF);
    check(word, 16'h7F7F);
    exc_mask = 6'h00;
    #1;
    check(word, 16'hFFFF);
    go(FSW_OP_MISC, 6'h00, 4'h0, 4'h0);
    check(word, 16'hFFFF);
    go(FSW_OP_INIT, 6'h00, 4'h0, 4'h0);
    check(word, 16'h0000);
    $display("test restore done");
  endtask : t_rest
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // Generous ceiling: the sequence needs well under 200 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      end_of_test();
    end
  end
  initial begin
    resetn = 1'b0;
    exc_mask = 6'h00;
    repeat (8) @(posedge mclk);
    #1;
    resetn = 1'b1;
    check(word, 16'h0000);
    t_walk();
    t_mask();
    t_cond();
    t_rest();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
